/* rtl/sfcp_pkg.sv */
// constants for the serial nonvolatile memory front end
package sfcp_pkg;
    // op-codes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    // array geometry
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam logic [12:0] ADDR_LAST = 13'h1FFF;
    localparam logic [12:0] ADDR_FIRST = 13'h0000;
    localparam logic [12:0] PROT_QUARTER_BASE = 13'h1800;
    localparam logic [12:0] PROT_HALF_BASE = 13'h1000;
    // status byte field positions
    localparam int SB_PIN_EN = 7;
    localparam int SB_BP_HI = 3;
    localparam int SB_BP_LO = 2;
    localparam int SB_LATCH = 1;
    // nonvolatile fields {pin enable, bp hi, bp lo} at first power-up
    localparam logic [2:0] NV_INIT = 3'h0;
    // bit counter reset and last values
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // powerup_delay before the first frame, and its cycle count at 25 MHz
    localparam int CLK_PERIOD_NS = 40;
    localparam int POWERUP_DELAY_NS = 1000;
    localparam int POWERUP_CYCLES =
        (POWERUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PU_CNT_RST = 8'h00;
    // serial state machine
    typedef enum logic [2:0] {
        SFCP_OPCODE = 3'b000,
        SFCP_ADDR_HI = 3'b001,
        SFCP_ADDR_LO = 3'b010,
        SFCP_MEM_RD = 3'b011,
        SFCP_MEM_WR = 3'b100,
        SFCP_STAT_RD = 3'b101,
        SFCP_STAT_WR = 3'b110,
        SFCP_IGNORE = 3'b111
    } sfcp_state_t;
endpackage : sfcp_pkg

/* rtl/sfcp_top.sv */
// serial command, status and array logic of the nonvolatile memory
`timescale 1ns/100ps
`default_nettype none

module sfcp_top (
    // system clock and reset pin
    input wire logic clock,
    input wire logic arst_n,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    // hardware write protect pin
    input wire logic wp_n,
    // system side status
    output logic powerup_ready,
    output logic frame_busy,
    output logic array_write_pulse
);

    ////////////////////////////////////////////////////////////////////
    // link domain: frame reset and decode

    wire frame_rst_n = arst_n & ~cs_n;

    sfcp_pkg::sfcp_state_t state_reg;
    sfcp_pkg::sfcp_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] in_shift_reg;
    logic [7:0] out_shift_reg;
    logic so_reg;
    logic is_read_reg;
    logic [12:0] addr_reg;
    logic wel_reg;
    logic drop_reg;
    logic wtog_reg;
    logic wp_meta_reg;
    logic wp_sync_reg;
    // nonvolatile: no reset, keeps contents across resets
    logic [2:0] nv_reg = sfcp_pkg::NV_INIT;
    logic [7:0] mem [0:sfcp_pkg::MEM_DEPTH-1];

    wire [7:0] din = {in_shift_reg[6:0], si};
    wire byte_done = (bit_cnt_reg == sfcp_pkg::BIT_LAST);
    wire first_edge = (state_reg == sfcp_pkg::SFCP_OPCODE) &&
                      (bit_cnt_reg == sfcp_pkg::BIT_CNT_RST);
    wire op_done = byte_done && (state_reg == sfcp_pkg::SFCP_OPCODE);

    // latch flag reads zero once the clearing frame ends
    wire wel_vis = wel_reg & ~(drop_reg & cs_n);

    wire [7:0] status_byte = {nv_reg[2], 3'h0, nv_reg[1], nv_reg[0],
                              wel_vis, 1'b0};

    wire addr_prot = (nv_reg[1:0] == 2'h3) ||
        ((nv_reg[1:0] == 2'h2) && (addr_reg >= sfcp_pkg::PROT_HALF_BASE)) ||
        ((nv_reg[1:0] == 2'h1) && (addr_reg >= sfcp_pkg::PROT_QUARTER_BASE));

    // array gate: latch and block protect only
    wire mem_we = byte_done && (state_reg == sfcp_pkg::SFCP_MEM_WR) &&
                  wel_reg && !addr_prot;

    // latch set expected from master, and pin high too when pin enable is set
    wire stat_ok = wel_reg && !(nv_reg[2] && !wp_sync_reg);
    wire stat_we = byte_done && (state_reg == sfcp_pkg::SFCP_STAT_WR) &&
                   stat_ok;

    // 13-bit address, three top bits dropped
    wire [12:0] addr_full = {addr_reg[12:8], din};
    wire [12:0] addr_inc = (addr_reg == sfcp_pkg::ADDR_LAST) ?
                           sfcp_pkg::ADDR_FIRST : addr_reg + 13'h0001;
    wire stream_done = byte_done &&
                       ((state_reg == sfcp_pkg::SFCP_MEM_RD) ||
                        (state_reg == sfcp_pkg::SFCP_MEM_WR));

    // op-codes that drop the latch at frame end
    wire op_drops = op_done && ((din == sfcp_pkg::OP_LATCH_CLEAR) ||
                                (din == sfcp_pkg::OP_STATUS_WRITE) ||
                                (din == sfcp_pkg::OP_MEM_WRITE));

    // output loads: status after 05h, array data after address or byte
    wire load_stat = op_done && (din == sfcp_pkg::OP_STATUS_READ);
    wire load_first = byte_done && is_read_reg &&
                      (state_reg == sfcp_pkg::SFCP_ADDR_LO);
    wire load_next = byte_done && (state_reg == sfcp_pkg::SFCP_MEM_RD);
    wire [7:0] load_byte = load_stat ? status_byte :
                           load_first ? mem[addr_full] : mem[addr_inc];
    wire load_any = load_stat || load_first || load_next;

    ////////////////////////////////////////////////////////////////////
    // link domain: next state

    always_comb begin
        state_next = state_reg;
        if (byte_done) begin
            case (state_reg)
                sfcp_pkg::SFCP_OPCODE: begin
                    case (din)
                        sfcp_pkg::OP_STATUS_READ:
                            state_next = sfcp_pkg::SFCP_STAT_RD;
                        sfcp_pkg::OP_STATUS_WRITE:
                            state_next = sfcp_pkg::SFCP_STAT_WR;
                        sfcp_pkg::OP_MEM_READ:
                            state_next = sfcp_pkg::SFCP_ADDR_HI;
                        sfcp_pkg::OP_MEM_WRITE:
                            state_next = sfcp_pkg::SFCP_ADDR_HI;
                        default:
                            state_next = sfcp_pkg::SFCP_IGNORE;
                    endcase
                end
                sfcp_pkg::SFCP_ADDR_HI: state_next = sfcp_pkg::SFCP_ADDR_LO;
                sfcp_pkg::SFCP_ADDR_LO: begin
                    state_next = is_read_reg ? sfcp_pkg::SFCP_MEM_RD :
                                               sfcp_pkg::SFCP_MEM_WR;
                end
                sfcp_pkg::SFCP_MEM_RD: state_next = sfcp_pkg::SFCP_MEM_RD;
                sfcp_pkg::SFCP_MEM_WR: state_next = sfcp_pkg::SFCP_MEM_WR;
                default: state_next = sfcp_pkg::SFCP_IGNORE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link domain: frame registers, cleared while select is high

    // first rising edge after select fall takes bit 7
    // sample and launch on rising edge
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_reg <= sfcp_pkg::SFCP_OPCODE;
            bit_cnt_reg <= sfcp_pkg::BIT_CNT_RST;
            in_shift_reg <= 8'h00;
            is_read_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            in_shift_reg <= din;
            if (op_done) begin
                is_read_reg <= (din == sfcp_pkg::OP_MEM_READ);
            end
        end
    end

    // output launched on the rising edge
    // status byte shifted out after 05h
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_reg <= 1'b0;
            out_shift_reg <= 8'h00;
        end else if (load_any) begin
            so_reg <= load_byte[7];
            out_shift_reg <= {load_byte[6:0], 1'b0};
        end else begin
            so_reg <= out_shift_reg[7];
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
    end

    // address advances even when the byte is dropped
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            addr_reg <= sfcp_pkg::ADDR_FIRST;
        end else if (byte_done && state_reg == sfcp_pkg::SFCP_ADDR_HI) begin
            addr_reg <= {din[4:0], 8'h00};
        end else if (byte_done && state_reg == sfcp_pkg::SFCP_ADDR_LO) begin
            addr_reg <= addr_full;
        end else if (stream_done) begin
            addr_reg <= addr_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link domain: persistent state

    // pending drop committed at first edge of next frame
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            wel_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else begin
            if (op_done && din == sfcp_pkg::OP_LATCH_SET) begin
                wel_reg <= 1'b1;
            end else if (first_edge && drop_reg) begin
                wel_reg <= 1'b0;
            end
            if (op_drops) begin
                drop_reg <= 1'b1;
            end else if (first_edge) begin
                drop_reg <= 1'b0;
            end
        end
    end

    // protect pin only moves with the serial clock; stale by two edges
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            wp_meta_reg <= 1'b1;
            wp_sync_reg <= 1'b1;
            wtog_reg <= 1'b0;
        end else begin
            wp_meta_reg <= wp_n;
            wp_sync_reg <= wp_meta_reg;
            if (mem_we) begin
                wtog_reg <= ~wtog_reg;
            end
        end
    end

    always_ff @(posedge sck) begin
        if (stat_we) begin
            nv_reg <= {din[sfcp_pkg::SB_PIN_EN], din[sfcp_pkg::SB_BP_HI],
                       din[sfcp_pkg::SB_BP_LO]};
        end
    end

    // dropped bytes never reach the array
    always_ff @(posedge sck) begin
        if (mem_we) begin
            mem[addr_reg] <= din;
        end
    end

    assign so = so_reg;

    ////////////////////////////////////////////////////////////////////
    // system domain: crossings and power-up timer

    logic cs_meta_reg;
    logic cs_sync_reg;
    logic wt_meta_reg;
    logic wt_sync_reg;
    logic wt_prev_reg;
    logic busy_reg;
    logic wpulse_reg;
    logic ready_reg;
    logic [7:0] pu_cnt_reg;

    wire pu_done = (pu_cnt_reg ==
                    8'(sfcp_pkg::POWERUP_CYCLES));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            wt_meta_reg <= 1'b0;
            wt_sync_reg <= 1'b0;
            wt_prev_reg <= 1'b0;
            busy_reg <= 1'b0;
            wpulse_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            wt_meta_reg <= wtog_reg;
            wt_sync_reg <= wt_meta_reg;
            wt_prev_reg <= wt_sync_reg;
            busy_reg <= ~cs_sync_reg;
            wpulse_reg <= wt_sync_reg ^ wt_prev_reg;
        end
    end

    // ready flag marks end of powerup_delay
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pu_cnt_reg <= sfcp_pkg::PU_CNT_RST;
            ready_reg <= 1'b0;
        end else if (!pu_done) begin
            pu_cnt_reg <= pu_cnt_reg + 8'h01;
        end else begin
            ready_reg <= 1'b1;
        end
    end

    assign powerup_ready = ready_reg;
    assign frame_busy = busy_reg;
    assign array_write_pulse = wpulse_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_latch_set: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        (op_done && din == sfcp_pkg::OP_LATCH_SET) |=> wel_reg)
        else $error("latch not set after 06h");

    chk_status_fixed: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        load_stat |=> (so_reg == $past(status_byte[7])) &&
                      (out_shift_reg[7:5] == 3'h0) &&
                      (out_shift_reg[1] == 1'b0))
        else $error("status byte layout wrong");

    chk_status_out: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        load_stat ##1 1'b1 [*4] |=> so_reg == $past(status_byte[3], 5))
        else $error("status bit 3 not shifted out");

    chk_block_guard: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        mem_we |-> (nv_reg[1:0] == 2'h0) ||
                   ((nv_reg[1:0] == 2'h1) && (addr_reg < 13'h1800)) ||
                   ((nv_reg[1:0] == 2'h2) && (addr_reg < 13'h1000)))
        else $error("write into protected block");

    chk_status_keep: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        (byte_done && state_reg == sfcp_pkg::SFCP_STAT_WR && !stat_ok)
        |=> $stable(nv_reg))
        else $error("refused status write changed bits");

    chk_addr_wrap: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        (stream_done && addr_reg == 13'h1FFF) |=> addr_reg == 13'h0000)
        else $error("address did not wrap");

    chk_one_opcode: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        (state_reg == sfcp_pkg::SFCP_IGNORE) |=>
            (state_reg == sfcp_pkg::SFCP_IGNORE) && !op_done)
        else $error("second op-code decoded");

    chk_byte_group: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        byte_done |=> bit_cnt_reg == 3'h0 ##7 byte_done)
        else $error("byte boundary lost");

    chk_latch_drop: assert property (
        @(posedge sck) disable iff (!frame_rst_n)
        op_drops |=> drop_reg && wel_reg == $past(wel_reg))
        else $error("latch drop not pending");

    chk_ready_time: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(ready_reg) |-> $past(pu_cnt_reg) == 8'h19)
        else $error("ready flag at wrong time");

endmodule : sfcp_top

`default_nettype wire

/* test/sfcp_spi_master.sv */
// serial bus master model driving the memory front end
`timescale 1ns/100ps
`default_nettype none

module sfcp_spi_master (
    // serial link
    output var logic sck,
    output var logic cs_n,
    output var logic si,
    input wire logic so
);
    logic [7:0] txb [0:7];
    logic [7:0] rxb [0:7];
    logic mode3;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        mode3 = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // one op-code per select, op-code byte first
    task automatic xfer(input int n);
        int k;
        int b;
        // mode 3 idles high, first edge comes from a fall
        sck = mode3;
        #3;
        cs_n = 1'b0;
        #6;
        for (k = 0; k < n; k++) begin
            // whole bytes, most significant bit first
            for (b = 7; b >= 0; b--) begin
                sck = 1'b0;
                si = txb[k][b];
                #6;
                rxb[k] = {rxb[k][6:0], so};
                sck = 1'b1;
                #6;
            end
        end
        if (!mode3) begin
            sck = 1'b0;
        end
        #6;
        cs_n = 1'b1;
        // released data line shows inverse, not a held value
        si = ~si;
        #12;
    endtask : xfer
endmodule : sfcp_spi_master

`default_nettype wire

/* test/tb.sv */
// self-checking bench for the memory front end
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clock;
    logic arst_n;
    logic wp_n;
    wire sck;
    wire cs_n;
    wire si;
    wire so;
    wire powerup_ready;
    wire frame_busy;
    wire array_write_pulse;
    int num_errors;
    int cmp_count;
    int pulses = 0;
    int busy_cyc = 0;

    sfcp_top dut (.clock(clock), .arst_n(arst_n), .sck(sck),
        .cs_n(cs_n), .si(si), .so(so), .wp_n(wp_n),
        .powerup_ready(powerup_ready), .frame_busy(frame_busy),
        .array_write_pulse(array_write_pulse));
    sfcp_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

    always #20 clock = ~clock;

    always @(posedge clock) begin
        if (array_write_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    // select seen on the system side, a few clocks late
    always @(posedge clock) begin
        if (frame_busy === 1'b1) begin
            busy_cyc <= busy_cyc + 1;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic chk8(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk_cnt(input string what, input int exp,
        input int got);
        cmp_count++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic reset_dut();
        int i;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        // no frame until the power-up wait is over
        for (i = 0; i < 60 && powerup_ready !== 1'b1; i++) begin
            @(negedge clock);
        end
        chk8("ready", 8'h01, {7'h00, powerup_ready});
    endtask : reset_dut

    task automatic send1(input logic [7:0] c);
        m.txb[0] = c;
        m.xfer(1);
    endtask : send1

    task automatic set_wp(input logic v);
        @(posedge clock);
        wp_n <= v;
        repeat (2) @(posedge clock);
    endtask : set_wp

    task automatic wr_status(input logic [7:0] v);
        m.txb[0] = sfcp_pkg::OP_STATUS_WRITE;
        m.txb[1] = v;
        m.xfer(2);
    endtask : wr_status

    // status reads use mode 3, all else mode 0
    task automatic rd_status(input logic [7:0] exp);
        m.mode3 = 1'b1;
        m.txb[0] = sfcp_pkg::OP_STATUS_READ;
        m.txb[1] = 8'h00;
        m.xfer(2);
        m.mode3 = 1'b0;
        // one status byte after the op-code
        chk8("status", exp, m.rxb[1]);
    endtask : rd_status

    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d0,
        input logic [7:0] d1, input int n, input int exp);
        int p0;
        int b0;
        p0 = pulses;
        b0 = busy_cyc;
        m.txb[0] = sfcp_pkg::OP_MEM_WRITE;
        m.txb[1] = a[15:8];
        m.txb[2] = a[7:0];
        m.txb[3] = d0;
        m.txb[4] = d1;
        m.xfer(3 + n);
        // write pulse lags the frame by a few system clocks
        repeat (8) @(posedge clock);
        chk_cnt("writes", exp, pulses - p0);
        chk_cnt("busy seen", 1, (busy_cyc > b0) ? 1 : 0);
        chk8("busy idle", 8'h00, {7'h00, frame_busy});
    endtask : wr_mem

    task automatic rd_mem(input logic [15:0] a, input logic [7:0] e0,
        input logic [7:0] e1);
        m.txb[0] = sfcp_pkg::OP_MEM_READ;
        m.txb[1] = a[15:8];
        m.txb[2] = a[7:0];
        m.xfer(5);
        chk8("data0", e0, m.rxb[3]);
        chk8("data1", e1, m.rxb[4]);
    endtask : rd_mem

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        wp_n = 1'b1;
        reset_dut();
        rd_status(8'h00);
        send1(sfcp_pkg::OP_LATCH_SET);
        rd_status(8'h02);
        send1(sfcp_pkg::OP_LATCH_CLEAR);
        rd_status(8'h00);
        m.txb[1] = sfcp_pkg::OP_LATCH_CLEAR;
        send1(sfcp_pkg::OP_LATCH_SET);
        m.txb[0] = sfcp_pkg::OP_LATCH_SET;
        m.xfer(2);
        rd_status(8'h02);
        wr_mem(16'hFFFF, 8'h3C, 8'h5A, 2, 2);
        rd_status(8'h00);
        rd_mem(16'hFFFF, 8'h3C, 8'h5A);
        wr_mem(16'h0000, 8'h77, 8'h77, 1, 0);
        rd_mem(16'h1FFF, 8'h3C, 8'h5A);
        wr_status(8'hFF);
        rd_status(8'h00);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_status(8'h44);
        rd_status(8'h04);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_mem(16'hFFFF, 8'h99, 8'h66, 2, 1);
        rd_mem(16'hFFFF, 8'h3C, 8'h66);
        send1(sfcp_pkg::OP_LATCH_SET);
        // latch and bit 0 written as ones must not stick
        wr_status(8'h83);
        rd_status(8'h80);
        set_wp(1'b0);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_mem(16'h2000, 8'h77, 8'h00, 1, 1);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_status(8'h0C);
        rd_status(8'h80);
        set_wp(1'b1);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_status(8'h8C);
        rd_status(8'h8C);
        send1(sfcp_pkg::OP_LATCH_SET);
        wr_mem(16'h0000, 8'h88, 8'h00, 1, 0);
        rd_mem(16'hFFFF, 8'h3C, 8'h77);
        send1(sfcp_pkg::OP_LATCH_SET);
        rd_status(8'h8E);
        reset_dut();
        rd_status(8'h8C);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
